// ---- dit_regs.vh ----
// Constants for the dual interval timer: field positions, reset values and timing counts.
`ifndef DIT_REGS_VH
`define DIT_REGS_VH

// Auxiliary control field positions.
`define DIT_ACR_TB_PULSE      5
`define DIT_ACR_TA_FREERUN    6
`define DIT_ACR_TA_WAVE       7

// Flag and enable register bit positions.
`define DIT_FLAG_TB           5
`define DIT_FLAG_TA           6
`define DIT_FLAG_SUMMARY      7
`define DIT_IER_SETCLR        7
`define DIT_FLAG_BITS         7

// Reset values.
`define DIT_COUNT_RST         16'hffff
`define DIT_LATCH_RST         8'hff
`define DIT_FLAG_RST          7'h00
`define DIT_ENABLE_RST        7'h00
`define DIT_ZERO16            16'h0000

// Timing: system clock rate and default phase-two divider (one system clock per phase two).
`define DIT_SYS_CLK_MHZ       200
`define DIT_PHI2_DIV_DEF      1

`endif

// ---- dit_pulse_detect.v ----
// Negative pulse detector for the pulse count pin, sampled on each phase-two tick.
`timescale 1ns/10ps
module dit_pulse_detect (
   input  wire clk_sys,      // System clock.
   input  wire rst,          // Asynchronous reset, active high.
   input  wire phi2Tick,     // Phase-two enable pulse.
   input  wire pulseIn,      // Pulse count pin level.
   output wire pulseFall     // One-cycle pulse on a counted negative pulse.
);

   reg prevLevel_q;          // Level seen at the previous phase two.

   // Sampling only at phase two means a low shorter than one phase two may be missed.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prevLevel_q <= 1'b1;
      end else if (phi2Tick) begin
         prevLevel_q <= pulseIn;
      end
   end

   // A pulse counts when the pin is low at the leading edge of phase two after being high.
   assign pulseFall = phi2Tick & prevLevel_q & ~pulseIn;

endmodule // dit_pulse_detect

// ---- dit_irq_ctrl.v ----
// Interrupt flag and enable registers with the open-drain request output.
`timescale 1ns/10ps
`include "dit_regs.vh"
module dit_irq_ctrl (
   input  wire       clk_sys,     // System clock.
   input  wire       rst,         // Asynchronous reset, active high.
   input  wire [6:0] flagSet,     // Hardware set pulses, one per flag.
   input  wire [6:0] flagClr,     // Clear pulses, one per flag.
   input  wire       wrEnable,    // Enable register write strobe.
   input  wire [7:0] wrData,      // Write data.
   output wire [7:0] flagRead,    // Flag register read value.
   output wire [7:0] enableRead,  // Enable register read value.
   output wire       irqOut,      // Request pin output level.
   output wire       irqOe        // Request pin output enable.
);

   reg  [6:0] flag_q;
   reg  [6:0] enable_q;
   reg        irqActive_q;
   wire [6:0] flag_d;
   wire [6:0] enable_d;

   // A set arriving with a clear wins, so no event is lost.
   assign flag_d = (flag_q & ~flagClr) | flagSet;

   // Bit 7 of the write data chooses between setting and clearing the marked bits.
   assign enable_d = !wrEnable ? enable_q :
                     wrData[`DIT_IER_SETCLR] ? (enable_q | wrData[6:0]) :
                     (enable_q & ~wrData[6:0]);

   // Flags, enables and the summary all change together on the same edge.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flag_q      <= `DIT_FLAG_RST;
         enable_q    <= `DIT_ENABLE_RST;
         irqActive_q <= 1'b0;
      end else begin
         flag_q      <= flag_d;
         enable_q    <= enable_d;
         irqActive_q <= |(flag_d & enable_d);
      end
   end

   // The summary bit is not a flag and follows the enabled flags only.
   assign flagRead   = {irqActive_q, flag_q};
   assign enableRead = {1'b0, enable_q};

   // Open drain: the pin is only ever pulled low, never driven high.
   assign irqOut = 1'b0;
   assign irqOe  = irqActive_q;

endmodule // dit_irq_ctrl

// ---- dit_timer.v ----
// Dual 16-bit interval timer with wave output, pulse counting and interrupt flagging.
`timescale 1ns/10ps
`include "dit_regs.vh"

// Behaviour
// - Timer A has two 8-bit reload latches and a 16-bit counter decrementing per phase two.
// - Timer A zero sets its flag; request pulls low when enabled.
// - Auxiliary bits 6 and 7 select one-shot/free-run, with or without wave output.
// - Writing A count high clears flag, loads low latch into counter, starts.
// - One-shot with output enabled: wave pin low after start, high at time-out.
// - In one-shot, a high latch write leaves the running count alone.
// - After one-shot time-out A keeps counting; no new flag until flag cleared.
// - Free-run zero sets flag, inverts wave, reloads all 16 latch bits.
// - A flag clears by count high write, count low read, or flag write.
// - Writing either count high byte restarts the period; repeated writes prevent time-out.
// - Latch-only writes leave the running count; they set the next period.
// - Wave pin carries timer only when direction bit 7 and auxiliary bit 7 are set.
// - One auxiliary bit selects timer B one-shot timing or pin pulse counting.
// - Timer B has a low latch, low counter byte and high counter byte.
// - Timer B one-shot gives one flag per high write; keeps counting afterwards.
// - Timer B flag clears on count low read or count high write.
// - Pulse mode decrements per negative pin pulse, flags at zero, keeps counting.
// - Request is active low, open drain, when any enabled flag is set.
// - Flag register bit 7 reads one while any enabled interrupt is active.
// - Writing one to a flag bit clears that flag; bit 7 is not cleared.
// - Enable writes set or clear marked bits according to data bit 7.
module dit_timer #(
   parameter PHI2_DIV = `DIT_PHI2_DIV_DEF,   // System clocks per phase two.
   parameter DIV_W    = 8                    // Width of the phase-two divider.
) (
   input  wire        clk_sys,             // System clock, 200 MHz.
   input  wire        rst,                 // Asynchronous reset, active high.
   input  wire [7:0]  auxControlReg,       // Auxiliary control register contents.
   input  wire        portBDirection7,     // Port B direction bit 7.
   input  wire        portBOutputLatch7,   // Port B output latch bit 7.
   input  wire [7:0]  wrData,              // Host write data.
   input  wire        wrTaLatchLo,         // Write timer A low latch.
   input  wire        wrTaLatchHi,         // Write timer A high latch.
   input  wire        wrTaCountHi,         // Write timer A count high byte.
   input  wire        rdTaCountLo,         // Read of timer A count low byte.
   input  wire        wrTbLatchLo,         // Write timer B low latch.
   input  wire        wrTbCountHi,         // Write timer B count high byte.
   input  wire        rdTbCountLo,         // Read of timer B count low byte.
   input  wire        wrFlagReg,           // Write of the flag register.
   input  wire        wrEnableReg,         // Write of the enable register.
   input  wire [4:0]  extFlagSet,          // Set pulses for the other flag sources.
   input  wire [4:0]  extFlagClr,          // Clear pulses for the other flag sources.
   input  wire        pulseCountPin,       // Pulse count pin level.
   output wire [15:0] timerACount,         // Timer A counter.
   output wire [15:0] timerALatch,         // Timer A latches, high and low.
   output wire [15:0] timerBCount,         // Timer B counter.
   output wire [7:0]  interruptFlagReg,    // Flag register read value.
   output wire [7:0]  interruptEnableReg,  // Enable register read value.
   output wire        waveOutputPinOut,    // Wave output pin level.
   output wire        waveOutputPinOe,     // Wave output pin drive enable.
   output wire        irqOut,              // Request pin level, always low.
   output wire        irqOe                // Request pin pull-down enable.
);

   // Shared down-count step; wrapping from zero to all ones is deliberate.
   function [15:0] dec16;
      input [15:0] value;
      begin
         dec16 = value - 16'h0001;
      end
   endfunction

   // True when a counter stands at zero.
   function isZero;
      input [15:0] value;
      begin
         isZero = (value == `DIT_ZERO16);
      end
   endfunction

   // The last divider count is cut to the divider width on purpose.
   localparam integer     DIV_LAST_INT = PHI2_DIV - 1;
   localparam [DIV_W-1:0] DIV_LAST     = DIV_LAST_INT[DIV_W-1:0];

   reg  [DIV_W-1:0] phi2Cnt_q;
   reg              phi2Tick_q;

   reg  [7:0]  taLatchLo_q;
   reg  [7:0]  taLatchHi_q;
   reg  [15:0] taCount_q;
   reg         taRunning_q;
   reg         taArmed_q;
   reg         taWave_q;

   reg  [7:0]  tbLatchLo_q;
   reg  [15:0] tbCount_q;
   reg         tbRunning_q;
   reg         tbArmed_q;

   reg         pinOut_q;
   reg         pinOe_q;

   wire        taFreeRun;
   wire        taWaveEn;
   wire        tbPulseMode;
   wire        taStep;
   wire        taTimeout;
   wire        taSet;
   wire        taClr;
   wire        tbFall;
   wire        tbStep;
   wire        tbSet;
   wire        tbClr;
   wire [6:0]  flagSet;
   wire [6:0]  flagClr;
   wire [4:0]  flagWrClr;

   // Mode selection from the auxiliary control bits.
   assign taFreeRun   = auxControlReg[`DIT_ACR_TA_FREERUN];
   assign taWaveEn    = auxControlReg[`DIT_ACR_TA_WAVE];
   assign tbPulseMode = auxControlReg[`DIT_ACR_TB_PULSE];

   // Phase-two enable divider; with the default of one it ticks every system clock.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phi2Cnt_q  <= {DIV_W{1'b0}};
         phi2Tick_q <= 1'b0;
      end else if (phi2Cnt_q >= DIV_LAST) begin
         phi2Cnt_q  <= {DIV_W{1'b0}};
         phi2Tick_q <= 1'b1;
      end else begin
         phi2Cnt_q  <= phi2Cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
         phi2Tick_q <= 1'b0;
      end
   end

   // Timer A time-out: a step taken while the counter stands at zero.
   assign taStep    = phi2Tick_q & taRunning_q;
   assign taTimeout = taStep & isZero(taCount_q);
   // A restart in the same cycle takes precedence over the time-out it replaces.
   assign taSet     = taTimeout & (taFreeRun | taArmed_q) & ~wrTaCountHi;
   assign taClr     = wrTaCountHi | rdTaCountLo |
                      (wrFlagReg & wrData[`DIT_FLAG_TA]);

   // Timer A latches; latch writes never touch the counter.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         taLatchLo_q <= `DIT_LATCH_RST;
         taLatchHi_q <= `DIT_LATCH_RST;
      end else begin
         if (wrTaLatchLo) begin
            taLatchLo_q <= wrData;
         end
         if (wrTaLatchHi | wrTaCountHi) begin
            taLatchHi_q <= wrData;
         end
      end
   end

   // Timer A counter: start or restart on a count high write, otherwise count or reload.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         taCount_q   <= `DIT_COUNT_RST;
         taRunning_q <= 1'b0;
      end else if (wrTaCountHi) begin
         taCount_q   <= {wrData, taLatchLo_q};
         taRunning_q <= 1'b1;
      end else if (taTimeout & taFreeRun) begin
         taCount_q   <= {taLatchHi_q, taLatchLo_q};
      end else if (taStep) begin
         taCount_q   <= dec16(taCount_q);
      end
   end

   // One-shot arming: the flag may be set once, then again only after it is cleared.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         taArmed_q <= 1'b0;
      end else if (taSet) begin
         taArmed_q <= 1'b0;
      end else if (taClr) begin
         taArmed_q <= 1'b1;
      end
   end

   // Timer A wave: low at start, high at one-shot time-out, toggled each free-run zero.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         taWave_q <= 1'b1;
      end else if (wrTaCountHi) begin
         taWave_q <= 1'b0;
      end else if (taTimeout & taFreeRun) begin
         taWave_q <= ~taWave_q;
      end else if (taTimeout & taArmed_q) begin
         taWave_q <= 1'b1;
      end
   end

   // Wave pin selection, registered so the pin never glitches between sources.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pinOut_q <= 1'b0;
         pinOe_q  <= 1'b0;
      end else if (portBDirection7 & taWaveEn) begin
         pinOut_q <= taWave_q;
         pinOe_q  <= 1'b1;
      end else begin
         pinOut_q <= portBOutputLatch7;
         pinOe_q  <= portBDirection7;
      end
   end

   // Negative pulses on the pulse count pin, taken at phase two.
   dit_pulse_detect u_pulse (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .phi2Tick  (phi2Tick_q),
      .pulseIn   (pulseCountPin),
      .pulseFall (tbFall)
   );

   // Timer B steps on phase two or on counted pulses, depending on mode.
   assign tbStep = tbRunning_q & (tbPulseMode ? tbFall : phi2Tick_q);
   assign tbSet  = tbStep & isZero(tbCount_q) & tbArmed_q & ~wrTbCountHi;
   assign tbClr  = rdTbCountLo | wrTbCountHi |
                   (wrFlagReg & wrData[`DIT_FLAG_TB]);

   // Timer B low latch, written only by the host.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tbLatchLo_q <= `DIT_LATCH_RST;
      end else if (wrTbLatchLo) begin
         tbLatchLo_q <= wrData;
      end
   end

   // Timer B counter never reloads; it wraps and keeps counting after time-out.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tbCount_q   <= `DIT_COUNT_RST;
         tbRunning_q <= 1'b0;
      end else if (wrTbCountHi) begin
         tbCount_q   <= {wrData, tbLatchLo_q};
         tbRunning_q <= 1'b1;
      end else if (tbStep) begin
         tbCount_q   <= dec16(tbCount_q);
      end
   end

   // Timer B arming: only a count high write allows another flag.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tbArmed_q <= 1'b0;
      end else if (wrTbCountHi) begin
         tbArmed_q <= 1'b1;
      end else if (tbSet) begin
         tbArmed_q <= 1'b0;
      end
   end

   // Flag set and clear vectors; the other five sources come from outside.
   assign flagWrClr = wrFlagReg ? wrData[4:0] : 5'h00;
   assign flagSet   = {taSet, tbSet, extFlagSet};
   assign flagClr   = {taClr, tbClr, extFlagClr | flagWrClr};

   // Flag and enable registers with the request output.
   dit_irq_ctrl u_irq (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .flagSet    (flagSet),
      .flagClr    (flagClr),
      .wrEnable   (wrEnableReg),
      .wrData     (wrData),
      .flagRead   (interruptFlagReg),
      .enableRead (interruptEnableReg),
      .irqOut     (irqOut),
      .irqOe      (irqOe)
   );

   // Read values come straight from the counter and latch flip-flops.
   assign timerACount      = taCount_q;
   assign timerALatch      = {taLatchHi_q, taLatchLo_q};
   assign timerBCount      = tbCount_q;
   assign waveOutputPinOut = pinOut_q;
   assign waveOutputPinOe  = pinOe_q;

endmodule // dit_timer

// ---- dit_timer_props.sv ----
// Concurrent checks on the dual interval timer ports.
`timescale 1ns/10ps
module dit_timer_props (
   input wire        clk_sys,             // Clock.
   input wire        rst,                 // Reset, active high.
   input wire [7:0]  auxControlReg,       // Mode bits.
   input wire        portBDirection7,     // Direction bit 7.
   input wire        portBOutputLatch7,   // Output latch bit 7.
   input wire [7:0]  wrData,              // Write data.
   input wire        wrTaCountHi,         // Timer A count high write.
   input wire        wrTbCountHi,         // Timer B count high write.
   input wire        wrFlagReg,           // Flag register write.
   input wire        wrEnableReg,         // Enable register write.
   input wire [4:0]  extFlagSet,          // Other flag set pulses.
   input wire [15:0] timerACount,         // Timer A counter.
   input wire [15:0] timerALatch,         // Timer A latches.
   input wire [15:0] timerBCount,         // Timer B counter.
   input wire [7:0]  interruptFlagReg,    // Flag register.
   input wire [7:0]  interruptEnableReg,  // Enable register.
   input wire        waveOutputPinOut,    // Wave pin level.
   input wire        irqOut,              // Request level.
   input wire        irqOe                // Request pull-down enable.
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // A time-out edge that no retrigger overrides, and the wave pin routing condition.
   wire aZero  = timerACount == 16'h0000 && !wrTaCountHi;
   wire waveOn = auxControlReg[7] && portBDirection7;

   a_irq_any_enabled: assert property (irqOe == |(interruptFlagReg[6:0] & interruptEnableReg[6:0]))
      else $error("request enable disagrees with flags and enables");
   a_summary_irq: assert property (interruptFlagReg[7] == irqOe)
      else $error("summary bit disagrees with request");
   a_irq_pin_low: assert property (!irqOut)
      else $error("request pin drives high");
   a_a_count_load: assert property (wrTaCountHi |=> timerACount == {$past(wrData),
      timerALatch[7:0]} && timerALatch[15:8] == $past(wrData) && !interruptFlagReg[6])
      else $error("timer A count high write misloaded");
   a_a_count_step: assert property (wrTaCountHi ##1 (!wrTaCountHi && timerACount != 16'h0000)
      |=> timerACount == $past(timerACount) - 16'h0001)
      else $error("timer A did not step down");
   a_free_reload: assert property (auxControlReg[6] && aZero |=> interruptFlagReg[6] &&
      timerACount == $past(timerALatch)) else $error("free-run reload wrong");
   a_oneshot_wave_low: assert property (auxControlReg[7:6] == 2'b10 && portBDirection7 &&
      wrTaCountHi |=> ##1 !waveOutputPinOut) else $error("one-shot pulse not low");
   a_wave_toggles: assert property (auxControlReg[6] && waveOn && aZero |=> ##1
      waveOutputPinOut != $past(waveOutputPinOut)) else $error("wave not inverted");
   a_port_latch_pin: assert property (!waveOn |=> waveOutputPinOut == $past(portBOutputLatch7))
      else $error("wave pin not following output latch");
   a_flag_write_clr: assert property (wrFlagReg |=> (interruptFlagReg[4:0] &
      $past(wrData[4:0] & ~extFlagSet)) == 5'h00) else $error("flag write left flag");
   a_enable_write: assert property (wrEnableReg |=> interruptEnableReg == {1'b0,
      $past(wrData[7]) ? $past(interruptEnableReg[6:0] | wrData[6:0]) :
      $past(interruptEnableReg[6:0] & ~wrData[6:0])})
      else $error("enable write wrong");
   a_b_count_load: assert property (wrTbCountHi |=> timerBCount[15:8] == $past(wrData) &&
      !interruptFlagReg[5]) else $error("timer B count high write wrong");
endmodule // dit_timer_props

bind dit_timer dit_timer_props chk (.*);

// ---- dit_host.sv ----
// Host model driving the timer strobes and the pulse count pin.
`timescale 1ns/10ps
module dit_host (
   input  wire       clk_sys,   // Clock.
   output reg  [8:0] strb,      // One strobe per access kind.
   output reg  [7:0] dat,       // Write data.
   output reg        pulsePin   // Pulse count pin, idles high.
);
   // Idle bus and a high pin from time zero.
   initial begin
      strb = 9'h000;
      dat = 8'h00;
      pulsePin = 1'b1;
   end
   // One access held across one sampling edge; released data shows its inverse.
   task acc(input integer k, input [7:0] d);
      begin
         @(posedge clk_sys);
         strb <= 9'h001 << k;
         dat <= d;
         @(posedge clk_sys);
         strb <= 9'h000;
         dat <= ~d;
      end
   endtask
   // Low for two edges so the pulse straddles a phase-two edge.
   task pulse;
      begin
         @(posedge clk_sys);
         pulsePin <= 1'b0;
         repeat (2) @(posedge clk_sys);
         pulsePin <= 1'b1;
         repeat (2) @(posedge clk_sys);
      end
   endtask
endmodule // dit_host

// ---- dit_timer_tb.sv ----
// Self-checking bench for the dual interval timer.
`timescale 1ns/10ps
module dit_timer_tb;
   localparam TALL = 0, TALH = 1, TACH = 2, TARD = 3, TBLL = 4, TBCH = 5, TBRD = 6;
   localparam FLG = 7, ENA = 8;
   reg         clk_sys = 1'b0;
   reg         rst = 1'b1;
   reg  [7:0]  aux = 8'h00;
   reg         dir7 = 1'b0;
   reg         orb7 = 1'b0;
   reg  [4:0]  xSet = 5'h00;
   reg  [4:0]  xClr = 5'h00;
   wire [8:0]  strb;
   wire [7:0]  dat, flg, ena;
   wire        pulsePin, pin, pinOe, irqOe;
   wire [15:0] cntA, latA, cntB;
   integer     failCount = 0;
   integer     nTests = 0;

   dit_host host (.clk_sys(clk_sys), .strb(strb), .dat(dat), .pulsePin(pulsePin));
   dit_timer dut (
      .clk_sys(clk_sys), .rst(rst), .auxControlReg(aux), .portBDirection7(dir7),
      .portBOutputLatch7(orb7), .wrData(dat), .wrTaLatchLo(strb[0]), .wrTaLatchHi(strb[1]),
      .wrTaCountHi(strb[2]), .rdTaCountLo(strb[3]), .wrTbLatchLo(strb[4]),
      .wrTbCountHi(strb[5]), .rdTbCountLo(strb[6]), .wrFlagReg(strb[7]),
      .wrEnableReg(strb[8]), .extFlagSet(xSet), .extFlagClr(xClr), .pulseCountPin(pulsePin),
      .timerACount(cntA), .timerALatch(latA), .timerBCount(cntB), .interruptFlagReg(flg),
      .interruptEnableReg(ena), .waveOutputPinOut(pin), .waveOutputPinOe(pinOe), .irqOut(),
      .irqOe(irqOe));

   // Free-running 200 MHz clock.
   initial forever #2.5 clk_sys = ~clk_sys;

   task chk(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         nTests = nTests + 1;
         if (seen !== exp) begin
            failCount = failCount + 1;
            $display("BAD %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // Sampling on falling edges keeps checks clear of the launching edge.
   task nap(input integer n);
      repeat (n) @(negedge clk_sys);
   endtask
   task results;
      begin
         $display("Checks %0d mismatches %0d", nTests, failCount);
         if (failCount == 0 && nTests > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask

   // The whole sequence needs under 150 cycles; this cuts a hang short.
   initial begin
      repeat (3000) @(posedge clk_sys);
      failCount = failCount + 1;
      results;
   end

   // Main sequence of accesses and expected values.
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      nap(1);
      chk("cntA", cntA, 16'hffff);
      chk("latA", latA, 16'hffff);
      chk("flg", flg, 8'h00);
      host.acc(ENA, 8'hc1);
      nap(1);
      chk("ena", ena, 8'h41);
      host.acc(ENA, 8'h01);
      nap(1);
      chk("ena", ena, 8'h40);
      host.acc(ENA, 8'ha0);
      nap(1);
      chk("ena", ena, 8'h60);
      // One-shot with the pulse on the wave pin; a high latch write mid-count.
      @(posedge clk_sys);
      aux <= 8'h80;
      dir7 <= 1'b1;
      orb7 <= 1'b1;
      host.acc(TALL, 8'h04);
      host.acc(TACH, 8'h00);
      nap(1);
      chk("cntA", cntA, 16'h0004);
      host.acc(TALH, 8'h12);
      nap(1);
      chk("cntA", cntA, 16'h0002);
      chk("latA", latA, 16'h1204);
      chk("pin", pin, 1'b0);
      nap(3);
      chk("flg", flg, 8'hc0);
      chk("irqOe", irqOe, 1'b1);
      chk("cntA", cntA, 16'hffff);
      nap(1);
      chk("pin", pin, 1'b1);
      host.acc(TARD, 8'h00);
      nap(1);
      chk("flg", flg, 8'h00);
      chk("irqOe", irqOe, 1'b0);
      // Pin routing falls back to the output latch unless both bits are set.
      // The wave state stands high here, so a low pin proves the latch is routed.
      @(posedge clk_sys);
      dir7 <= 1'b0;
      orb7 <= 1'b0;
      nap(2);
      chk("pin", pin, 1'b0);
      chk("pinOe", pinOe, 1'b0);
      @(posedge clk_sys);
      aux <= 8'h00;
      dir7 <= 1'b1;
      orb7 <= 1'b0;
      nap(2);
      chk("pin", pin, 1'b0);
      chk("pinOe", pinOe, 1'b1);
      // Free-run with a latch-only write, reload, flag write and re-arm.
      @(posedge clk_sys);
      aux <= 8'hc0;
      host.acc(TALL, 8'h04);
      host.acc(TACH, 8'h00);
      host.acc(TALL, 8'h03);
      nap(1);
      chk("cntA", cntA, 16'h0002);
      chk("latA", latA, 16'h0003);
      nap(3);
      chk("cntA", cntA, 16'h0003);
      chk("flgA", flg[6], 1'b1);
      host.acc(FLG, 8'h40);
      nap(1);
      chk("flgA", flg[6], 1'b0);
      nap(2);
      chk("flg", flg, 8'hc0);
      repeat (6) host.acc(TACH, 8'h00);
      nap(1);
      chk("flgA", flg[6], 1'b0);
      chk("cntA", cntA, 16'h0003);
      @(posedge clk_sys);
      aux <= 8'h00;
      host.acc(ENA, 8'h40);
      nap(1);
      chk("ena", ena, 8'h20);
      // Timer B one-shot, then masking with timer A's flag still pending.
      host.acc(TBLL, 8'h05);
      host.acc(TBCH, 8'h00);
      nap(1);
      chk("cntB", cntB, 16'h0005);
      nap(6);
      chk("flgB", flg[5], 1'b1);
      chk("irqOe", irqOe, 1'b1);
      host.acc(TBRD, 8'h00);
      nap(1);
      chk("flgB", flg[5], 1'b0);
      chk("irqOe", irqOe, 1'b0);
      // Timer B pulse counting.
      @(posedge clk_sys);
      aux <= 8'h20;
      host.acc(TBLL, 8'h02);
      host.acc(TBCH, 8'h00);
      nap(4);
      chk("cntB", cntB, 16'h0002);
      host.pulse;
      host.pulse;
      nap(2);
      chk("cntB", cntB, 16'h0000);
      host.pulse;
      nap(2);
      chk("cntB", cntB, 16'hffff);
      chk("flgB", flg[5], 1'b1);
      host.acc(TBCH, 8'h00);
      nap(1);
      chk("flgB", flg[5], 1'b0);
      // Other flag sources: set, clear pulse, and clear by flag write.
      @(posedge clk_sys);
      xSet <= 5'h03;
      @(posedge clk_sys);
      xSet <= 5'h00;
      xClr <= 5'h02;
      @(posedge clk_sys);
      xClr <= 5'h00;
      nap(1);
      chk("flgX", flg[4:0], 5'h01);
      host.acc(FLG, 8'h01);
      nap(1);
      chk("flgX", flg[4:0], 5'h00);
      results;
   end
endmodule // dit_timer_tb
